// ### rtl/fcd_pkg.sv
/*
 fcd_pkg: constants, states and report layout of the frame check
 detector.
 assumes one 200 MHz clock that also stands for the internal oscillator.
*/
package fcd_pkg;
   // clock period in ns
   localparam int CLK_NS = 5;
   localparam int CRC16_W = 16;
   localparam int CRC32_W = 32;
   // generator polynomials, msb first, zero start value
   localparam logic [15:0] POLY16 = 16'h8005;
   localparam logic [31:0] POLY32 = 32'h04C11DB7;
   localparam int NFRAMES = 4;
   localparam int FRAME_BITS = 64;
   localparam int DIV_EXP_TOP = 8;
   localparam int DIV_EXP_W = 4;
   localparam int DIV_CNT_W = 8;
   // least fault report spacing, 2.43 us, in ns
   localparam int REP_MIN_NS = 2430;
   localparam int REP_GAP_CYC = (REP_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_W = 16;
   localparam int IDX_W = 16;
   localparam logic STATUS_N_RST = 1'b1;
   localparam logic [1:0] KIND_NONE = 2'h0;
   localparam logic [1:0] KIND_SINGLE = 2'h1;
   localparam logic [1:0] KIND_DOUBLE_ADJ = 2'h2;
   localparam logic [1:0] KIND_OTHER = 2'h3;

   typedef enum logic [1:0] {
      FCD_IDLE = 2'b00,
      FCD_SCAN = 2'b01,
      FCD_LOC = 2'b10,
      FCD_HOLD = 2'b11
   } fcd_state_t;

   typedef struct packed {
      logic [1:0] kind;
      logic [IDX_W-1:0] frame;
      logic [IDX_W-1:0] bit_pos;
   } fcd_report_t;
endpackage : fcd_pkg

// ### rtl/fcd_crc_serial.sv
/*
 fcd_crc_serial: one bit per enabled cycle crc engine, msb first.
 assumes the caller holds bit_in stable in the enabled cycle.
*/
`timescale 1ns/10ps
module fcd_crc_serial #(
   parameter int W = 16,
   parameter logic [W-1:0] POLY = 16'h8005
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic init_in,
   input wire logic en_in,
   input wire logic bit_in,
   output logic [W-1:0] crc_out,
   output logic [W-1:0] next_out
);
   logic [W-1:0] crc_q;

   // zero start keeps the code linear, so a syndrome depends on errors only
   assign next_out = {crc_q[W-2:0], 1'b0} ^
                     ((crc_q[W-1] ^ bit_in) ? POLY : '0);
   assign crc_out = crc_q;

   always_ff @(posedge clk_in) begin
      if (rst_in || init_in) begin
         crc_q <= '0;
      end else if (en_in) begin
         crc_q <= next_out;
      end
   end
endmodule : fcd_crc_serial

// ### rtl/fcd_detector.sv
/*
 fcd_detector: frame check during load and endless frame scrub afterwards.
 assumes load and injection inputs come from logic on clk_in; the
 reconfiguration and error pins come from outside and are synchronised.
*/
`timescale 1ns/10ps
module fcd_detector #(
   parameter int NFRAMES = fcd_pkg::NFRAMES,
   parameter int FRAME_BITS = fcd_pkg::FRAME_BITS,
   parameter int REP_GAP_CYC = fcd_pkg::REP_GAP_CYC,
   localparam int FI = $clog2(NFRAMES),
   localparam int BI = $clog2(FRAME_BITS)
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic reconfig_n_in,
   input wire logic ed_enable_in,
   input wire logic [fcd_pkg::DIV_EXP_W-1:0] div_exp_in,
   input wire logic cfg_valid_in,
   input wire logic cfg_bit_in,
   input wire logic cfg_last_in,
   input wire logic [15:0] cfg_crc16_in,
   input wire logic [31:0] cfg_crc32_in,
   input wire logic inj_valid_in,
   input wire logic [FI-1:0] inj_frame_in,
   input wire logic [BI-1:0] inj_bit_in,
   input wire logic user_io_out_in,
   input wire logic user_io_oe_in,
   input wire logic err_pin_in,
   output logic cfg_status_n_out,
   output logic user_mode_out,
   output logic err_pin_out,
   output logic err_pin_oe_out,
   output logic user_io_in_out,
   output logic [31:0] syndrome_out,
   output fcd_pkg::fcd_report_t fault_report_out,
   output logic report_valid_out
);
   localparam logic [BI-1:0] LASTB = BI'(FRAME_BITS - 1);
   localparam logic [FI-1:0] LASTF = FI'(NFRAMES - 1);

   logic rc_s1_q, rc_s2_q, rc_s3_q, rc_flt_q;
   logic io_s1_q, io_s2_q, io_s3_q, io_flt_q;
   logic clr;
   logic [fcd_pkg::DIV_CNT_W-1:0] div_cnt_q, div_mask;
   logic [fcd_pkg::DIV_EXP_W-1:0] div_exp_c;
   logic tick;
   logic [FRAME_BITS-1:0] config_memory_cells_q [NFRAMES];
   logic [31:0] stored_crc_q [NFRAMES];
   logic [BI-1:0] cfg_bit_q;
   logic [FI-1:0] cfg_frame_q;
   logic status_n_q, user_mode_q, cfg_acc;
   logic [15:0] c16_val, c16_next;
   logic [31:0] c32_val, c32_next;
   fcd_pkg::fcd_state_t state_q;
   logic [FI-1:0] sf_q, sf_inc;
   logic [BI-1:0] sb_q;
   logic [31:0] syn_q, loc_v_q, loc_p_q;
   logic [BI-1:0] loc_k_q, loc_pos_q;
   logic [1:0] loc_kind_q;
   logic err_q, scan_bit, scan_end, frame_ok;
   logic [fcd_pkg::GAP_W-1:0] gap_q;
   logic gap_open, rep_wr;
   fcd_pkg::fcd_report_t fault_report_reg_q;
   logic rep_v_q, pin_q, pin_oe_q, uio_q;

   // pin inputs: three stages, a change is taken when stages 2 and 3 agree
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rc_s1_q <= 1'b1;
         rc_s2_q <= 1'b1;
         rc_s3_q <= 1'b1;
         rc_flt_q <= 1'b1;
      end else begin
         rc_s1_q <= reconfig_n_in;
         rc_s2_q <= rc_s1_q;
         rc_s3_q <= rc_s2_q;
         if (rc_s2_q == rc_s3_q) begin
            rc_flt_q <= rc_s3_q;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         io_s1_q <= 1'b0;
         io_s2_q <= 1'b0;
         io_s3_q <= 1'b0;
         io_flt_q <= 1'b0;
      end else begin
         io_s1_q <= err_pin_in;
         io_s2_q <= io_s1_q;
         io_s3_q <= io_s2_q;
         if (io_s2_q == io_s3_q) begin
            io_flt_q <= io_s3_q;
         end
      end
   end

   // reset and a reconfiguration request are the only ways to stop the scrub
   assign clr = rst_in || !rc_flt_q;

   // checker tick; exponents above the top value are clamped
   assign div_exp_c = (div_exp_in > fcd_pkg::DIV_EXP_W'(fcd_pkg::DIV_EXP_TOP))
                      ? fcd_pkg::DIV_EXP_W'(fcd_pkg::DIV_EXP_TOP) : div_exp_in;
   assign div_mask = fcd_pkg::DIV_CNT_W'((9'h001 << div_exp_c) - 9'h001);
   assign tick = (div_cnt_q == div_mask);

   always_ff @(posedge clk_in) begin
      if (clr || tick) begin
         div_cnt_q <= '0;
      end else begin
         div_cnt_q <= div_cnt_q + 1'b1;
      end
   end

   // load path
   assign cfg_acc = cfg_valid_in && !user_mode_q && status_n_q;

   fcd_crc_serial #(
      .W(fcd_pkg::CRC16_W),
      .POLY(fcd_pkg::POLY16)
   ) u_crc16 (
      .clk_in(clk_in),
      .rst_in(clr),
      .init_in(cfg_acc && cfg_last_in),
      .en_in(cfg_acc),
      .bit_in(cfg_bit_in),
      .crc_out(c16_val),
      .next_out(c16_next)
   );

   always_ff @(posedge clk_in) begin
      if (clr) begin
         cfg_bit_q <= '0;
         cfg_frame_q <= '0;
         status_n_q <= fcd_pkg::STATUS_N_RST;
         user_mode_q <= 1'b0;
      end else if (cfg_acc) begin
         if (cfg_last_in) begin
            cfg_bit_q <= '0;
            if (c16_next != cfg_crc16_in) begin
               status_n_q <= 1'b0;
            end else if (cfg_frame_q == LASTF) begin
               user_mode_q <= 1'b1;
            end else begin
               cfg_frame_q <= cfg_frame_q + 1'b1;
            end
         end else begin
            cfg_bit_q <= cfg_bit_q + 1'b1;
         end
      end
   end

   // memory cells hold no reset; they are rewritten by every load
   always_ff @(posedge clk_in) begin
      if (cfg_acc) begin
         config_memory_cells_q[cfg_frame_q][cfg_bit_q] <= cfg_bit_in;
         if (cfg_last_in) begin
            stored_crc_q[cfg_frame_q] <= cfg_crc32_in;
         end
      end else if (inj_valid_in && user_mode_q) begin
         config_memory_cells_q[inj_frame_in][inj_bit_in] <=
            !config_memory_cells_q[inj_frame_in][inj_bit_in];
      end
   end

   // scrub path
   assign scan_bit = config_memory_cells_q[sf_q][sb_q];
   assign scan_end = (state_q == fcd_pkg::FCD_SCAN) && tick && (sb_q == LASTB);
   assign frame_ok = (c32_next == stored_crc_q[sf_q]);
   assign sf_inc = (sf_q == LASTF) ? '0 : sf_q + 1'b1;

   fcd_crc_serial #(
      .W(fcd_pkg::CRC32_W),
      .POLY(fcd_pkg::POLY32)
   ) u_crc32 (
      .clk_in(clk_in),
      .rst_in(clr),
      .init_in(scan_end),
      .en_in((state_q == fcd_pkg::FCD_SCAN) && tick),
      .bit_in(scan_bit),
      .crc_out(c32_val),
      .next_out(c32_next)
   );

   // the 32-bit code flags every pattern up to five flips in a frame
   always_ff @(posedge clk_in) begin
      if (clr) begin
         state_q <= fcd_pkg::FCD_IDLE;
         sf_q <= '0;
         sb_q <= '0;
         syn_q <= '0;
         err_q <= 1'b0;
         loc_v_q <= '0;
         loc_p_q <= '0;
         loc_k_q <= '0;
         loc_pos_q <= '0;
         loc_kind_q <= fcd_pkg::KIND_NONE;
      end else begin
         case (state_q)
            fcd_pkg::FCD_IDLE: begin
               if (user_mode_q && ed_enable_in) begin
                  state_q <= fcd_pkg::FCD_SCAN;
               end
            end
            fcd_pkg::FCD_SCAN: begin
               if (scan_end) begin
                  sb_q <= '0;
                  syn_q <= c32_next ^ stored_crc_q[sf_q];
                  if (frame_ok) begin
                     err_q <= 1'b0;
                     sf_q <= sf_inc;
                  end else begin
                     err_q <= 1'b1;
                     state_q <= fcd_pkg::FCD_LOC;
                     loc_v_q <= fcd_pkg::POLY32;
                     loc_p_q <= '0;
                     loc_k_q <= '0;
                  end
               end else if (tick) begin
                  sb_q <= sb_q + 1'b1;
               end
            end
            fcd_pkg::FCD_LOC: begin
               // loc_v is the syndrome of a lone flip at LASTB minus loc_k
               if (syn_q == loc_v_q) begin
                  loc_kind_q <= fcd_pkg::KIND_SINGLE;
                  loc_pos_q <= LASTB - loc_k_q;
                  state_q <= fcd_pkg::FCD_HOLD;
               end else if (loc_k_q != '0 &&
                            syn_q == (loc_v_q ^ loc_p_q)) begin
                  loc_kind_q <= fcd_pkg::KIND_DOUBLE_ADJ;
                  loc_pos_q <= LASTB - loc_k_q;
                  state_q <= fcd_pkg::FCD_HOLD;
               end else if (loc_k_q == LASTB) begin
                  loc_kind_q <= fcd_pkg::KIND_OTHER;
                  loc_pos_q <= '0;
                  state_q <= fcd_pkg::FCD_HOLD;
               end else begin
                  loc_p_q <= loc_v_q;
                  loc_v_q <= {loc_v_q[30:0], 1'b0} ^
                             (loc_v_q[31] ? fcd_pkg::POLY32 : '0);
                  loc_k_q <= loc_k_q + 1'b1;
               end
            end
            fcd_pkg::FCD_HOLD: begin
               if (gap_open) begin
                  state_q <= fcd_pkg::FCD_SCAN;
                  sf_q <= sf_inc;
               end
            end
            default: begin
               state_q <= fcd_pkg::FCD_IDLE;
            end
         endcase
      end
   end

   // report spacing is counted in checker ticks, so it grows as they slow
   assign gap_open = (gap_q == fcd_pkg::GAP_W'(REP_GAP_CYC));
   assign rep_wr = (state_q == fcd_pkg::FCD_HOLD) && gap_open;

   always_ff @(posedge clk_in) begin
      if (clr) begin
         gap_q <= fcd_pkg::GAP_W'(REP_GAP_CYC);
         fault_report_reg_q <= '0;
         rep_v_q <= 1'b0;
      end else begin
         rep_v_q <= rep_wr;
         if (rep_wr) begin
            fault_report_reg_q.kind <= loc_kind_q;
            fault_report_reg_q.frame <= fcd_pkg::IDX_W'(sf_q);
            fault_report_reg_q.bit_pos <= fcd_pkg::IDX_W'(loc_pos_q);
            gap_q <= '0;
         end else if (tick && !gap_open) begin
            gap_q <= gap_q + 1'b1;
         end
      end
   end

   // error pin doubles as user i/o while ed_enable_in is low
   always_ff @(posedge clk_in) begin
      if (clr) begin
         pin_q <= 1'b0;
         pin_oe_q <= 1'b0;
         uio_q <= 1'b0;
      end else if (ed_enable_in) begin
         pin_q <= err_q;
         pin_oe_q <= 1'b1;
         uio_q <= 1'b0;
      end else begin
         pin_q <= user_io_out_in;
         pin_oe_q <= user_io_oe_in;
         uio_q <= io_flt_q;
      end
   end

   assign cfg_status_n_out = status_n_q;
   assign user_mode_out = user_mode_q;
   assign err_pin_out = pin_q;
   assign err_pin_oe_out = pin_oe_q;
   assign user_io_in_out = uio_q;
   assign syndrome_out = syn_q;
   assign fault_report_out = fault_report_reg_q;
   assign report_valid_out = rep_v_q;

   // helper: clock cycles since the last report write
   logic [fcd_pkg::GAP_W-1:0] since_q;
   always_ff @(posedge clk_in) begin
      if (clr) begin
         since_q <= '1;
      end else if (rep_wr) begin
         since_q <= 16'h0001;
      end else if (since_q != '1) begin
         since_q <= since_q + 1'b1;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   load_step_a: assert property (cfg_acc && !cfg_last_in |=>
      c16_val == $past(c16_next)) else $error("load crc did not step");
   load_fail_a: assert property (cfg_acc && cfg_last_in &&
      c16_next != cfg_crc16_in && rc_flt_q |=> !cfg_status_n_out)
      else $error("status not pulled low on load mismatch");
   pin_user_a: assert property (!ed_enable_in && rc_flt_q |=>
      err_pin_oe_out == $past(user_io_oe_in))
      else $error("pin not handed to user i/o");
   scan_clean_a: assert property (scan_end && frame_ok && rc_flt_q
      |=> syndrome_out == 32'h0 ##1 !err_pin_out || !ed_enable_in)
      else $error("clean frame left a syndrome");
   scan_bad_a: assert property (scan_end && !frame_ok && rc_flt_q
      |=> syndrome_out != 32'h0 && state_q == fcd_pkg::FCD_LOC)
      else $error("mismatch not flagged");
   loc_single_a: assert property (state_q == fcd_pkg::FCD_LOC &&
      syn_q == loc_v_q && rc_flt_q |=> loc_kind_q == fcd_pkg::KIND_SINGLE
      && loc_pos_q == LASTB - $past(loc_k_q))
      else $error("single flip misplaced");
   rep_space_a: assert property (rep_wr |->
      since_q >= fcd_pkg::GAP_W'(REP_GAP_CYC))
      else $error("fault reports too close");
   recfg_stop_a: assert property (!rc_flt_q |=>
      state_q == fcd_pkg::FCD_IDLE && !user_mode_q)
      else $error("scrub survived reconfiguration");
   tick_div_a: assert property ($past(tick) && tick |->
      div_exp_c == '0) else $error("tick faster than divisor");
   inject_a: assert property (inj_valid_in && user_mode_q && !cfg_acc
      |=> config_memory_cells_q[$past(inj_frame_in)][$past(inj_bit_in)]
      != $past(config_memory_cells_q[inj_frame_in][inj_bit_in]))
      else $error("injection did not flip the bit");

   user_mode_c: cover property (user_mode_q && ed_enable_in);
   mismatch_c: cover property (scan_end && !frame_ok);
   report_c: cover property (rep_v_q &&
      fault_report_reg_q.kind == fcd_pkg::KIND_DOUBLE_ADJ);
endmodule : fcd_detector

// ### sim/fcd_cfg_source.sv
/*
 fcd_cfg_source: load-side source sending every frame with both checks.
 assumes the detector's clock and the widths of fcd_pkg.
*/
`timescale 1ns/10ps
module fcd_cfg_source (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic go_in,
   input wire logic bad_en_in,
   input wire logic [1:0] bad_frame_in,
   output logic valid_out,
   output logic bit_out,
   output logic last_out,
   output logic [15:0] crc16_out,
   output logic [31:0] crc32_out
);
   int f;
   int k;
   logic run_q;
   logic [63:0] cur;
   logic [31:0] c16;
   logic [31:0] c32;
   function automatic logic [31:0] crc_calc(input logic [63:0] d,
      input logic wide);
      logic fb;
      logic [31:0] c;
      c = '0;
      for (int i = 63; i >= 0; i--) begin
         fb = (wide ? c[31] : c[15]) ^ d[i];
         c = c << 1;
         if (fb) c = c ^ (wide ? fcd_pkg::POLY32 : {16'h0, fcd_pkg::POLY16});
      end
      return wide ? c : {16'h0, c[15:0]};
   endfunction : crc_calc
   assign cur = 64'hA5C3_0F1E_9D2B_7684 ^ (64'(f) * 64'h0F0F_3333_5555_00FF);
   assign c16 = crc_calc(cur, 1'b0);
   assign c32 = crc_calc(cur, 1'b1);
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         run_q <= 1'b0;
         f <= 0;
         k <= 0;
         valid_out <= 1'b0;
         last_out <= 1'b0;
         bit_out <= 1'b0;
      end else if (go_in && !run_q) begin
         run_q <= 1'b1;
         f <= 0;
         k <= 0;
      end else if (run_q) begin
         valid_out <= 1'b1;
         bit_out <= cur[63-k];
         last_out <= (k == 63);
         k <= (k == 63) ? 0 : k + 1;
         if (k == 63) begin
            f <= f + 1;
            run_q <= (f < fcd_pkg::NFRAMES - 1);
         end
      end else begin
         valid_out <= 1'b0;
         last_out <= 1'b0;
         bit_out <= ~bit_out;
      end
   end
   // check lines carry junk outside the last bit, the last value inverted on every cycle
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         crc16_out <= 16'h0;
         crc32_out <= 32'h0;
      end else if (run_q && k == 63) begin
         crc16_out <= c16[15:0] ^ {15'h0, bad_en_in && 32'(bad_frame_in) == f};
         crc32_out <= c32;
      end else begin
         crc16_out <= ~crc16_out;
         crc32_out <= ~crc32_out;
      end
   end
endmodule : fcd_cfg_source

// ### sim/fcd_detector_tb.sv
/*
 fcd_detector_tb: load, scrub, report and pin checks of fcd_detector.
 assumes fcd_cfg_source as the load side and a short report gap.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
   $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module fcd_detector_tb;
   localparam int GAP = 100;
   localparam int FB = fcd_pkg::FRAME_BITS;
   localparam int NF = fcd_pkg::NFRAMES;
   typedef struct {
      logic [3:0] dv;
      logic [1:0] fr;
      logic [63:0] mask;
      logic [1:0] kind;
      logic [15:0] pos;
   } fcd_row_t;
   fcd_row_t rows [8] = '{
      '{4'h0, 2'h1, 64'h20, fcd_pkg::KIND_SINGLE, 16'h5},
      '{4'h2, 2'h0, 64'h8000_0000_0000_0000, fcd_pkg::KIND_SINGLE, 16'h3F},
      '{4'h3, 2'h3, 64'h30_0000, fcd_pkg::KIND_DOUBLE_ADJ, 16'h14},
      '{4'h1, 2'h2, 64'hC000_0000_0000_0000, fcd_pkg::KIND_DOUBLE_ADJ, 16'h3E},
      '{4'h0, 2'h0, 64'h4000_0400, fcd_pkg::KIND_OTHER, 16'h0},
      '{4'h0, 2'h1, 64'h282, fcd_pkg::KIND_OTHER, 16'h0},
      '{4'h0, 2'h2, 64'h1111_0000, fcd_pkg::KIND_OTHER, 16'h0},
      '{4'h0, 2'h3, 64'h100_0000_000F, fcd_pkg::KIND_OTHER, 16'h0}};
   int error_cnt = 0;
   int comparisons = 0;
   logic clk_in = 1'b0, rst_in = 1'b1, reconfig_n_in = 1'b1;
   logic ed_enable_in = 1'b1, inj_valid_in = 1'b0, go = 1'b0, bad_en = 1'b0;
   logic user_io_out_in = 1'b0, user_io_oe_in = 1'b0, ext_lvl = 1'b0;
   logic [3:0] div_exp_in = 4'h0;
   logic [1:0] inj_frame_in = 2'h0;
   logic [5:0] inj_bit_in = 6'h0;
   logic cfg_valid_in, cfg_bit_in, cfg_last_in, err_pin_in;
   logic [15:0] cfg_crc16_in;
   logic [31:0] cfg_crc32_in, syndrome_out;
   logic cfg_status_n_out, user_mode_out, err_pin_out, err_pin_oe_out;
   logic user_io_in_out, report_valid_out;
   fcd_pkg::fcd_report_t fault_report_out, rep;
   // pin level seen by every party
   assign err_pin_in = err_pin_oe_out ? err_pin_out : ext_lvl;
   fcd_cfg_source src (.clk_in(clk_in), .rst_in(rst_in), .go_in(go),
      .bad_en_in(bad_en), .bad_frame_in(2'h2), .valid_out(cfg_valid_in),
      .bit_out(cfg_bit_in), .last_out(cfg_last_in),
      .crc16_out(cfg_crc16_in), .crc32_out(cfg_crc32_in));
   fcd_detector #(.REP_GAP_CYC(GAP)) dut (.clk_in(clk_in), .rst_in(rst_in),
      .reconfig_n_in(reconfig_n_in), .ed_enable_in(ed_enable_in),
      .div_exp_in(div_exp_in), .cfg_valid_in(cfg_valid_in),
      .cfg_bit_in(cfg_bit_in), .cfg_last_in(cfg_last_in),
      .cfg_crc16_in(cfg_crc16_in), .cfg_crc32_in(cfg_crc32_in),
      .inj_valid_in(inj_valid_in), .inj_frame_in(inj_frame_in),
      .inj_bit_in(inj_bit_in), .user_io_out_in(user_io_out_in),
      .user_io_oe_in(user_io_oe_in), .err_pin_in(err_pin_in),
      .cfg_status_n_out(cfg_status_n_out), .user_mode_out(user_mode_out),
      .err_pin_out(err_pin_out), .err_pin_oe_out(err_pin_oe_out),
      .user_io_in_out(user_io_in_out), .syndrome_out(syndrome_out),
      .fault_report_out(fault_report_out),
      .report_valid_out(report_valid_out));
   initial begin
      forever #2.5 clk_in = ~clk_in;
   end
   task automatic close_out();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out
   task automatic do_reset();
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      #1;
      `CHK(cfg_status_n_out, fcd_pkg::STATUS_N_RST)
      `CHK({user_mode_out, err_pin_oe_out, syndrome_out}, 34'h0)
   endtask : do_reset
   task automatic load(input logic bad, output int nl, output logic l2);
      logic l1;
      bad_en <= bad;
      go <= 1'b1;
      @(posedge clk_in);
      go <= 1'b0;
      {nl, l1, l2} = '0;
      repeat (NF * FB + 20) begin
         @(posedge clk_in);
         #1;
         l2 = l1;
         l1 = cfg_valid_in & cfg_last_in;
         if (l1) nl++;
         if (!cfg_status_n_out || user_mode_out) break;
      end
   endtask : load
   // one flip per pulse, two cycles apart
   task automatic inject(input logic [1:0] fr, input logic [63:0] m);
      for (int i = 0; i < FB; i++) begin
         if (m[i]) begin
            @(posedge clk_in);
            inj_valid_in <= 1'b1;
            inj_frame_in <= fr;
            inj_bit_in <= 6'(i);
            @(posedge clk_in);
            inj_valid_in <= 1'b0;
         end
      end
   endtask : inject
   task automatic wait_pin(input logic lvl, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (err_pin_out !== lvl && n < lim);
      `CHK(err_pin_out, lvl)
   endtask : wait_pin
   task automatic quiet(input int dv);
      int bad;
      wait_pin(1'b0, 4 * (NF * FB << dv));
      bad = 0;
      repeat ((NF * FB) << dv) begin
         @(posedge clk_in);
         #1;
         if (err_pin_out !== 1'b0) bad++;
      end
      `CHK(bad, 0)
      `CHK(syndrome_out, 32'h0)
      `CHK(err_pin_oe_out, 1'b1)
   endtask : quiet
   initial begin
      #450000;
      error_cnt++;
      close_out();
   end
   initial begin
      int nl, n, nf, lim, lo, t0, got, minsp;
      logic l2, seen;
      logic [63:0] ev;
      do_reset();
      load(1'b0, nl, l2);
      `CHK(nl, NF)
      `CHK({l2, user_mode_out, cfg_status_n_out}, 3'h7)
      quiet(0);
      foreach (rows[r]) begin
         div_exp_in <= rows[r].dv;
         for (int i = 0; i < 64; i++) ev[63-i] = rows[r].mask[i];
         lim = 4 * ((NF * FB) << rows[r].dv) + 200;
         inject(rows[r].fr, rows[r].mask);
         wait_pin(1'b1, lim);
         wait_pin(1'b0, lim);
         wait_pin(1'b1, lim);
         `CHK(syndrome_out, src.crc_calc(ev, 1'b1))
         `CHK(syndrome_out != 32'h0, 1'b1)
         {nf, n, seen} = '0;
         while ((nf == 0 || !seen) && n < lim) begin
            @(posedge clk_in);
            #1;
            n++;
            if (report_valid_out === 1'b1) begin
               seen = 1'b1;
               rep = fault_report_out;
            end
            if (nf == 0 && err_pin_out !== 1'b1) nf = n;
         end
         lo = ((FB - 1) << rows[r].dv) + 3;
         // locating may pause the scan, hence the loose upper bound
         `CHK(nf >= lo && nf <= 2 * lo + (GAP << rows[r].dv), 1'b1)
         `CHK(seen, 1'b1)
         `CHK(rep.kind, rows[r].kind)
         if (rows[r].kind != fcd_pkg::KIND_OTHER) begin
            `CHK(rep.frame, 16'(rows[r].fr))
            `CHK(rep.bit_pos, rows[r].pos)
         end
         inject(rows[r].fr, rows[r].mask);
         quiet(rows[r].dv);
      end
      div_exp_in <= 4'h0;
      // last-bit flips in adjacent frames come closer than the gap
      inject(2'h1, 64'h8000_0000_0000_0000);
      inject(2'h2, 64'h8000_0000_0000_0000);
      {n, got, t0} = '0;
      minsp = 100000;
      while (got < 4 && n < 4000) begin
         @(posedge clk_in);
         #1;
         n++;
         if (report_valid_out === 1'b1) begin
            if (got > 0 && n - t0 < minsp) minsp = n - t0;
            t0 = n;
            got++;
         end
      end
      `CHK(got, 4)
      `CHK(minsp >= GAP && minsp <= GAP + FB, 1'b1)
      wait_pin(1'b1, 2000);
      wait_pin(1'b0, 2000);
      inject(2'h1, 64'h8000_0000_0000_0000);
      inject(2'h2, 64'h8000_0000_0000_0000);
      quiet(0);
      reconfig_n_in <= 1'b0;
      repeat (8) @(posedge clk_in);
      #1;
      `CHK({user_mode_out, err_pin_oe_out, cfg_status_n_out}, 3'h1)
      reconfig_n_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      load(1'b1, nl, l2);
      `CHK(nl, 3)
      `CHK({l2, cfg_status_n_out}, 2'h2)
      repeat (FB + 10) @(posedge clk_in);
      #1;
      `CHK({user_mode_out, cfg_status_n_out}, 2'h0)
      ed_enable_in <= 1'b0;
      do_reset();
      load(1'b0, nl, l2);
      user_io_oe_in <= 1'b1;
      user_io_out_in <= 1'b1;
      @(posedge clk_in);
      #1;
      `CHK({err_pin_oe_out, err_pin_out}, 2'h3)
      user_io_oe_in <= 1'b0;
      ext_lvl <= 1'b1;
      inject(2'h0, 64'h1);
      repeat (NF * FB + 100) @(posedge clk_in);
      #1;
      `CHK({err_pin_oe_out, user_io_in_out}, 2'h1)
      `CHK(syndrome_out, 32'h0)
      close_out();
   end
endmodule : fcd_detector_tb
